// ==== ifp_pkg.sv ====
// Package for the inverter fault-protection controller.
// Assumes comparator outputs arrive already synchronous to the 125 MHz clock.
package ifp_pkg;
	localparam int unsigned CLOCK_MHZ           = 125;
	// Secondary undervoltage qualification delay, in microseconds.
	localparam int unsigned UV_DELAY_US         = 250;
	localparam int unsigned UV_DELAY_CYCLES     = UV_DELAY_US * CLOCK_MHZ;
	localparam int unsigned UV_COUNT_W          = 16;
	localparam logic        FAULT_LATCH_RESET   = 1'b0;

	typedef enum logic [2:0] {
		IFP_SHUTDOWN = 3'b001,
		IFP_RUN      = 3'b010,
		IFP_FAULTED  = 3'b100
	} ifp_state_t;

	// Comparator inputs.
	typedef struct packed {
		logic primary_overcurrent;
		logic secondary_overvoltage;
		logic secondary_undervoltage;
		logic secondary_overcurrent;
		logic fault_timer_trip;
		logic lamp_feedback_a_low;
		logic lamp_feedback_b_low;
		logic undervoltage_lockout;
	} ifp_sense_t;

	// Gate and analog control requests.
	typedef struct packed {
		logic high_side_enable;
		logic low_side_enable;
		logic comp_discharge;
		logic timer_charge_high;
		logic timer_charge_low;
		logic light_sensor_supply;
	} ifp_drive_t;
endpackage

// ==== ifp_ctrl.sv ====
// Fault-protection and power-state control for a full-bridge lamp inverter.
// Assumes the bridge modulator supplies its high and low side requests and
// the dimming burst level, all synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

module ifp_ctrl
	import ifp_pkg::*;
#(
	parameter int unsigned UV_DELAY = UV_DELAY_CYCLES
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// Control
	input  wire logic       inverter_on_bit,
	input  wire logic       dimming_burst,
	input  wire logic       cycle_start,
	input  wire logic       high_side_request,
	input  wire logic       low_side_request,
	// Comparators
	input  wire ifp_sense_t sense,
	// Outputs
	output var  ifp_drive_t drive,
	output logic            fault_latched,
	output logic            enabled
);
	// A zero delay would wrap to the longest count and a long one would not fit.
	if (UV_DELAY < 1 || UV_DELAY >= (1 << UV_COUNT_W)) begin : g_bad_delay
		$error("UV_DELAY out of range for the counter");
	end

	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire logic rst_n = rst_sync_reg;

	ifp_state_t            state_reg, state_next;
	logic                  fault_reg, fault_next;
	logic                  blank_reg, blank_next;
	logic [UV_COUNT_W-1:0] uv_count_reg, uv_count_next;
	ifp_drive_t            drive_reg, drive_next;
	logic                  uv_expired;
	logic                  run_now;

	always_comb begin
		state_next    = state_reg;
		fault_next    = fault_reg;
		uv_count_next = uv_count_reg;
		uv_expired    = 1'b0;
		if (state_reg == IFP_RUN && dimming_burst &&
				sense.secondary_undervoltage) begin
			if (uv_count_reg >= UV_COUNT_W'(UV_DELAY - 1))
				uv_expired = 1'b1;
			else
				uv_count_next = uv_count_reg + 1'b1;
		end else begin
			uv_count_next = '0;
		end
		case (state_reg)
			IFP_SHUTDOWN: begin
				fault_next = FAULT_LATCH_RESET;
				if (inverter_on_bit)
					state_next = IFP_RUN;
			end
			IFP_RUN: begin
				if (!inverter_on_bit) begin
					state_next = IFP_SHUTDOWN;
				end else if (sense.fault_timer_trip) begin
					fault_next = 1'b1;
					state_next = IFP_FAULTED;
				end else if (uv_expired) begin
					state_next = IFP_FAULTED;
				end
			end
			IFP_FAULTED: begin
				// Only the on bit leaves this state; a fault never re-arms alone.
				if (!inverter_on_bit) begin
					fault_next = FAULT_LATCH_RESET;
					state_next = IFP_SHUTDOWN;
				end
			end
			default: begin
				state_next = IFP_SHUTDOWN;
				fault_next = FAULT_LATCH_RESET;
			end
		endcase
	end

	assign run_now = (state_reg == IFP_RUN) && (state_next == IFP_RUN);

	always_comb begin
		blank_next = blank_reg;
		// Blanking lasts to the next cycle start so a trip cannot chatter.
		if (cycle_start)
			blank_next = 1'b0;
		if (low_side_request && sense.primary_overcurrent)
			blank_next = 1'b1;
		drive_next = '0;
		if (run_now) begin
			drive_next.high_side_enable = high_side_request && !blank_next &&
				!sense.undervoltage_lockout;
			drive_next.low_side_enable = low_side_request &&
				!sense.undervoltage_lockout;
			drive_next.comp_discharge = sense.secondary_overvoltage ||
				sense.secondary_overcurrent;
			drive_next.timer_charge_high = sense.secondary_overcurrent;
			drive_next.timer_charge_low = sense.lamp_feedback_a_low ||
				sense.lamp_feedback_b_low;
			drive_next.light_sensor_supply = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= IFP_SHUTDOWN;
			fault_reg    <= FAULT_LATCH_RESET;
			blank_reg    <= 1'b0;
			uv_count_reg <= '0;
			drive_reg    <= '0;
		end else begin
			state_reg    <= state_next;
			fault_reg    <= fault_next;
			blank_reg    <= blank_next;
			uv_count_reg <= uv_count_next;
			drive_reg    <= drive_next;
		end
	end

	assign drive         = drive_reg;
	assign fault_latched = fault_reg;
	assign enabled       = (state_reg == IFP_RUN);

	gate_lockout_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		sense.undervoltage_lockout |=> !drive.high_side_enable &&
		!drive.low_side_enable)
		else $error("gate drive on under lockout");
	oc_blank_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		low_side_request && sense.primary_overcurrent |=>
		!drive.high_side_enable)
		else $error("high side on after overcurrent");
	oc_hold_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		blank_reg && !cycle_start |=> !drive.high_side_enable)
		else $error("high side back before cycle start");
	discharge_or_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		run_now |=> drive.comp_discharge ==
		($past(sense.secondary_overvoltage) ||
		$past(sense.secondary_overcurrent)))
		else $error("discharge enable mismatch");
	sec_current_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		run_now && sense.secondary_overcurrent |=>
		drive.comp_discharge && drive.timer_charge_high)
		else $error("secondary overcurrent response missing");
	uv_expiry_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		state_reg == IFP_RUN && dimming_burst &&
		sense.secondary_undervoltage &&
		uv_count_reg == UV_COUNT_W'(UV_DELAY - 1) |=> !enabled)
		else $error("undervoltage delay did not shut down");
	timer_fault_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		state_reg == IFP_RUN && inverter_on_bit &&
		sense.fault_timer_trip |=> fault_latched && !enabled)
		else $error("timer trip did not latch");
	fault_hold_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		fault_latched && inverter_on_bit |=> fault_latched)
		else $error("fault latch cleared with the on bit set");
	shutdown_drive_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		!inverter_on_bit |=> drive == '0)
		else $error("drive active in shutdown");
	shutdown_clear_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		!inverter_on_bit |=> !fault_latched && !enabled)
		else $error("fault latch held in shutdown");
	// The edge at which reset lifts still loads the reset state, so skip it.
	resume_on_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		rst_n && state_reg == IFP_SHUTDOWN && inverter_on_bit |=> enabled)
		else $error("no resume on enable");
	sensor_supply_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		!enabled |=> !drive.light_sensor_supply)
		else $error("sensor supply on while disabled");
	uv_restart_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		!sense.secondary_undervoltage |=> uv_count_reg == '0)
		else $error("undervoltage count not restarted");
	lamp_low_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		run_now && sense.lamp_feedback_a_low |=> drive.timer_charge_low)
		else $error("low timer charge missing");
	lamp_b_low_a: assert property (@(posedge clock)
		disable iff (!rst_n)
		run_now && sense.lamp_feedback_b_low |=> drive.timer_charge_low)
		else $error("low timer charge missing on second lamp");
endmodule

`default_nettype wire

// ==== ifp_far_side.sv ====
// Far-side model: sense comparators and the fault timer node.
// Assumes the bench sets comparator levels on cmp at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module ifp_far_side
	import ifp_pkg::*;
(
	input  wire logic       clock,
	input  wire ifp_sense_t cmp,
	input  wire ifp_drive_t drive,
	output var  ifp_sense_t sense
);
	int node;
	// The high charge current fills the node eight times faster.
	always_ff @(posedge clock) begin
		if (!drive.light_sensor_supply)
			node <= 0;
		else
			node <= node + (drive.timer_charge_high ? 8 : 0)
				+ (drive.timer_charge_low ? 1 : 0);
	end
	always_comb begin
		sense = cmp;
		sense.fault_timer_trip = (node >= 32);
	end
endmodule
`default_nettype wire

// ==== ifp_ctrl_tb_top.sv ====
// Testbench for the fault-protection controller.
// Assumes the far-side model turns the charge requests into a timer trip.
`timescale 1ns/1ps
`default_nettype none
module ifp_ctrl_tb_top;
	import ifp_pkg::*;
	logic       clock = 1'b0, reset_n = 1'b0, on = 1'b0, burst = 1'b0;
	logic       cs = 1'b0, hs = 1'b0, ls = 1'b0, fault_latched, enabled;
	ifp_sense_t cmp = '0, sense;
	ifp_drive_t drive;
	int         miscompares = 0, check_count = 0;
	always #4 clock = ~clock;
	ifp_ctrl #(.UV_DELAY(8)) i_dut (.clock(clock), .reset_n(reset_n),
		.inverter_on_bit(on), .dimming_burst(burst), .cycle_start(cs),
		.high_side_request(hs), .low_side_request(ls), .sense(sense),
		.drive(drive), .fault_latched(fault_latched), .enabled(enabled));
	ifp_far_side i_far (.clock(clock), .cmp(cmp), .drive(drive),
		.sense(sense));
	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic check(input string what, input logic [7:0] exp, got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_enable;
		on = 1'b1;
		step(3);
		check("enabled", 8'h01, enabled);
		check("drive", 8'h01, drive);
	endtask
	task automatic t_discharge;
		cmp.secondary_overvoltage = 1'b1;
		step(2);
		check("drive", 8'h09, drive);
		cmp.secondary_overvoltage = 1'b0;
		cmp.lamp_feedback_b_low = 1'b1;
		step(2);
		check("drive", 8'h03, drive);
		cmp.lamp_feedback_b_low = 1'b0;
	endtask
	task automatic t_gates;
		hs = 1'b1;
		ls = 1'b1;
		cmp.primary_overcurrent = 1'b1;
		step(2);
		cmp.primary_overcurrent = 1'b0;
		step(2);
		check("drive", 8'h11, drive);
		cs = 1'b1;
		step(1);
		cs = 1'b0;
		step(2);
		check("drive", 8'h31, drive);
		cmp.undervoltage_lockout = 1'b1;
		step(2);
		check("drive", 8'h01, drive);
		cmp.undervoltage_lockout = 1'b0;
		hs = 1'b0;
		ls = 1'b0;
	endtask
	task automatic t_timer;
		cmp.secondary_overcurrent = 1'b1;
		step(2);
		check("drive", 8'h0D, drive);
		step(6);
		check("fault", 8'h01, fault_latched);
		check("enabled", 8'h00, enabled);
		cmp.secondary_overcurrent = 1'b0;
		on = 1'b0;
		step(5);
		check("fault", 8'h00, fault_latched);
	endtask
	task automatic t_undervoltage;
		on = 1'b1;
		cmp.secondary_undervoltage = 1'b1;
		step(12);
		check("enabled", 8'h01, enabled);
		burst = 1'b1;
		step(7);
		cmp.secondary_undervoltage = 1'b0;
		step(1);
		cmp.secondary_undervoltage = 1'b1;
		step(6);
		check("enabled", 8'h01, enabled);
		step(5);
		check("enabled", 8'h00, enabled);
		check("drive", 8'h00, drive);
		cmp.secondary_undervoltage = 1'b0;
	endtask
	task automatic t_reset;
		on = 1'b0;
		step(2);
		on = 1'b1;
		cmp.secondary_overcurrent = 1'b1;
		step(8);
		check("fault", 8'h01, fault_latched);
		cmp.secondary_overcurrent = 1'b0;
		reset_n = 1'b0;
		step(1);
		check("fault", 8'h00, fault_latched);
		check("enabled", 8'h00, enabled);
		check("drive", 8'h00, drive);
		reset_n = 1'b1;
		step(2);
		check("enabled", 8'h00, enabled);
		step(2);
		check("enabled", 8'h01, enabled);
	endtask
	initial begin
		step(5);
		reset_n = 1'b1;
		step(3);
		t_enable();
		t_discharge();
		t_gates();
		t_timer();
		t_undervoltage();
		t_reset();
		final_report();
	end
	// The sequence needs under two microseconds.
	initial begin
		#20000;
		miscompares++;
		final_report();
	end
endmodule
`default_nettype wire
